//--- asrpc_regs.vh
`ifndef ASRPC_REGS_VH
`define ASRPC_REGS_VH

// register byte addresses on the apb port
`define ASRPC_ADDR_W 12
`define ASRPC_OFS_CHAN 12'h000
`define ASRPC_OFS_PERIOD 12'h004
`define ASRPC_OFS_STATUS 12'h008

// channel pairing codes held in the channel register
`define ASRPC_CHAN_W 3
`define ASRPC_CHAN_D12 3'h0
`define ASRPC_CHAN_D34 3'h1
`define ASRPC_CHAN_P1 3'h2
`define ASRPC_CHAN_P2 3'h3
`define ASRPC_CHAN_P3 3'h4
`define ASRPC_CHAN_P4 3'h5
`define ASRPC_CHAN_RST 3'h0

// analog input numbers driven on the mux outputs
`define ASRPC_AIN_1 3'h1
`define ASRPC_AIN_2 3'h2
`define ASRPC_AIN_3 3'h3
`define ASRPC_AIN_4 3'h4
`define ASRPC_AIN_COMMON 3'h6
`define ASRPC_AIN_NONE 3'h0

// output update period in master clock periods
`define ASRPC_PERIOD_W 16
`define ASRPC_PERIOD_RST 16'h1000
`define ASRPC_PERIOD_ONE 16'h0001

// data-ready high window before an update, in master clock periods
`define ASRPC_DATA_READY_N_HIGH_MCLK 16'h01f4

// bits in one output word
`define ASRPC_BITCNT_W 5
`define ASRPC_WORD_LAST 5'h17
`define ASRPC_BITCNT_ONE 5'h01

// status register field positions
`define ASRPC_ST_DATA_READY_N 0
`define ASRPC_ST_SYNC 1
`define ASRPC_ST_RESET 2
`define ASRPC_ST_PARK 3
`define ASRPC_ST_POL 4
`define ASRPC_ST_BITS_LO 8
`define ASRPC_ST_BITS_HI 12

`endif

//--- asrpc_sync2.v
`timescale 1ns/1ps
// two-flop synchroniser for a pin level
module asrpc_sync2 #(
    parameter RST_VAL = 1'b0
) (
    input wire i_clk,
    input wire i_rst,
    input wire i_d,
    output wire o_q
);
    reg meta_r;
    reg q_r;

    // first flop is read only by the second one
    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            meta_r <= RST_VAL;
            q_r <= RST_VAL;
        end else begin
            meta_r <= i_d;
            q_r <= meta_r;
        end
    end

    assign o_q = q_r;
endmodule

//--- asrpc_edge.v
`timescale 1ns/1ps
// rising and falling edge pulses of a synchronised level
module asrpc_edge #(
    parameter RST_VAL = 1'b0
) (
    input wire i_clk,
    input wire i_rst,
    input wire i_lvl,
    output wire o_rise,
    output wire o_fall
);
    reg prev_r;

    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            prev_r <= RST_VAL;
        end else begin
            prev_r <= i_lvl;
        end
    end

    assign o_rise = i_lvl & ~prev_r;
    assign o_fall = ~i_lvl & prev_r;
endmodule

//--- asrpc_top.v
// Function
// - polarity low: first serial clock edge rises, clock parks low.
// - polarity high: first serial clock edge falls, clock parks high.
// - serial clock may be continuous or bursty; bit state survives gaps.
// - sync low holds filter, filter and calibration sequencing in reset.
// - sync low also holds modulator in reset, released with the filter.
// - sync leaves serial interface alone, never forces data-ready high.
// - reset low: control, interface, filter, modulator back to power-on.
// - master clock output is the inverse of the master clock input.
// - channels pair input 1 against 2, or inputs 1-4 against common.
// - channels also pair input 3 positive against input 4 negative.
// - data-ready falls on a new word, rises after a full word read.
// - unread word: data-ready high 500 master clocks before next update.
//
// The placing of the registers and the APB slave port were left to the implementer.
`timescale 1ns/1ps
`include "asrpc_regs.vh"

module asrpc_top (
    input wire I_CLK_SYS,
    input wire I_RST,
    input wire I_PSEL,
    input wire I_PENABLE,
    input wire I_PWRITE,
    input wire [11:0] I_PADDR,
    input wire [31:0] I_PWDATA,
    output reg [31:0] O_PRDATA,
    output reg O_PREADY,
    output reg O_PSLVERR,
    input wire I_SCLK,
    input wire I_CLOCK_POLARITY_SELECT,
    input wire I_SYNC_N,
    input wire I_RESET_N,
    input wire I_MCLK_IN,
    output reg O_MCLK_OUT,
    output reg O_DATA_READY_N,
    output reg O_FILTER_RST,
    output reg O_MODULATOR_RST,
    output reg O_CAL_RST,
    output reg O_IF_RST,
    output reg O_SCLK_ACTIVE,
    output reg [2:0] O_MUX_POS,
    output reg [2:0] O_MUX_NEG
);
    wire sclk_s;
    wire pol_s;
    wire sync_n_s;
    wire reset_n_s;
    wire mclk_s;
    wire sclk_rise;
    wire sclk_fall;
    wire mclk_tick;
    wire sclk_act;
    wire sclk_parked;
    wire setup_ph;
    wire access_wr;
    wire [`ASRPC_PERIOD_W-1:0] last_cnt;
    wire [`ASRPC_PERIOD_W-1:0] window_cnt;

    reg rst_hold_r;
    reg sync_hold_r;
    reg [`ASRPC_CHAN_W-1:0] chan_r;
    reg [`ASRPC_PERIOD_W-1:0] period_r;
    reg [`ASRPC_PERIOD_W-1:0] upd_cnt_r;
    reg [`ASRPC_BITCNT_W-1:0] bit_cnt_r;
    reg data_ready_n_n_r;
    reg [31:0] rdata_nxt;
    reg rd_err_nxt;
    reg [2:0] pos_nxt;
    reg [2:0] neg_nxt;

    // every pin from outside the system clock passes two flops
    asrpc_sync2 #(.RST_VAL(1'b0)) u_sync_sclk (
        .i_clk(I_CLK_SYS),
        .i_rst(I_RST),
        .i_d(I_SCLK),
        .o_q(sclk_s)
    );
    asrpc_sync2 #(.RST_VAL(1'b0)) u_sync_pol (
        .i_clk(I_CLK_SYS),
        .i_rst(I_RST),
        .i_d(I_CLOCK_POLARITY_SELECT),
        .o_q(pol_s)
    );
    asrpc_sync2 #(.RST_VAL(1'b0)) u_sync_syncn (
        .i_clk(I_CLK_SYS),
        .i_rst(I_RST),
        .i_d(I_SYNC_N),
        .o_q(sync_n_s)
    );
    asrpc_sync2 #(.RST_VAL(1'b0)) u_sync_rstn (
        .i_clk(I_CLK_SYS),
        .i_rst(I_RST),
        .i_d(I_RESET_N),
        .o_q(reset_n_s)
    );
    asrpc_sync2 #(.RST_VAL(1'b0)) u_sync_mclk (
        .i_clk(I_CLK_SYS),
        .i_rst(I_RST),
        .i_d(I_MCLK_IN),
        .o_q(mclk_s)
    );

    // edges of the sampled serial and master clocks
    asrpc_edge #(.RST_VAL(1'b0)) u_edge_sclk (
        .i_clk(I_CLK_SYS),
        .i_rst(I_RST),
        .i_lvl(sclk_s),
        .o_rise(sclk_rise),
        .o_fall(sclk_fall)
    );
    asrpc_edge #(.RST_VAL(1'b0)) u_edge_mclk (
        .i_clk(I_CLK_SYS),
        .i_rst(I_RST),
        .i_lvl(mclk_s),
        .o_rise(mclk_tick),
        .o_fall()
    );

    // active edge is the first edge out of the park level
    assign sclk_act = pol_s ? sclk_fall : sclk_rise;
    assign sclk_parked = (sclk_s == pol_s);

    // update counter targets: last count and start of the high window
    assign last_cnt = period_r - `ASRPC_PERIOD_ONE;
    assign window_cnt = last_cnt - `ASRPC_DATA_READY_N_HIGH_MCLK;

    // hold flags set at once, but release only on a master clock edge
    // so dependent logic restarts aligned to the converter clock
    always @(posedge I_CLK_SYS or posedge I_RST) begin
        if (I_RST) begin
            rst_hold_r <= 1'b1;
            sync_hold_r <= 1'b1;
        end else begin
            if (!reset_n_s) begin
                rst_hold_r <= 1'b1;
            end else if (mclk_tick) begin
                rst_hold_r <= 1'b0;
            end
            if (!sync_n_s) begin
                sync_hold_r <= 1'b1;
            end else if (mclk_tick) begin
                sync_hold_r <= 1'b0;
            end
        end
    end

    // reset outputs toward filter, modulator, calibration and interface
    always @(posedge I_CLK_SYS or posedge I_RST) begin
        if (I_RST) begin
            O_FILTER_RST <= 1'b1;
            O_MODULATOR_RST <= 1'b1;
            O_CAL_RST <= 1'b1;
            O_IF_RST <= 1'b1;
        end else begin
            O_FILTER_RST <= rst_hold_r | sync_hold_r;
            // modulator shares the filter's release edge
            O_MODULATOR_RST <= rst_hold_r | sync_hold_r;
            O_CAL_RST <= rst_hold_r | sync_hold_r;
            // sync never touches the serial interface
            O_IF_RST <= rst_hold_r;
        end
    end

    // inverted master clock out; lags the pin by the sampling delay
    always @(posedge I_CLK_SYS or posedge I_RST) begin
        if (I_RST) begin
            O_MCLK_OUT <= 1'b1;
        end else begin
            O_MCLK_OUT <= ~mclk_s;
        end
    end

    // filter sequencing: output update counter in master clock periods
    always @(posedge I_CLK_SYS or posedge I_RST) begin
        if (I_RST) begin
            upd_cnt_r <= {`ASRPC_PERIOD_W{1'b0}};
        end else if (rst_hold_r || sync_hold_r) begin
            upd_cnt_r <= {`ASRPC_PERIOD_W{1'b0}};
        end else if (mclk_tick) begin
            if (upd_cnt_r >= last_cnt) begin
                upd_cnt_r <= {`ASRPC_PERIOD_W{1'b0}};
            end else begin
                upd_cnt_r <= upd_cnt_r + `ASRPC_PERIOD_ONE;
            end
        end
    end

    // data-ready and bit count; bit count advances only on active edges,
    // so pauses in the serial clock never lose position
    always @(posedge I_CLK_SYS or posedge I_RST) begin
        if (I_RST) begin
            data_ready_n_n_r <= 1'b1;
            bit_cnt_r <= {`ASRPC_BITCNT_W{1'b0}};
        end else if (rst_hold_r) begin
            data_ready_n_n_r <= 1'b1;
            bit_cnt_r <= {`ASRPC_BITCNT_W{1'b0}};
        end else if (!sync_hold_r && mclk_tick &&
                     upd_cnt_r >= last_cnt) begin
            // update wins over a read edge in the same cycle
            data_ready_n_n_r <= 1'b0;
            bit_cnt_r <= {`ASRPC_BITCNT_W{1'b0}};
        end else begin
            // sync holding leaves data-ready as it is
            if (!sync_hold_r && mclk_tick && !data_ready_n_n_r &&
                upd_cnt_r == window_cnt) begin
                data_ready_n_n_r <= 1'b1;
            end
            if (sclk_act && !data_ready_n_n_r) begin
                if (bit_cnt_r == `ASRPC_WORD_LAST) begin
                    data_ready_n_n_r <= 1'b1;
                    bit_cnt_r <= {`ASRPC_BITCNT_W{1'b0}};
                end else begin
                    bit_cnt_r <= bit_cnt_r + `ASRPC_BITCNT_ONE;
                end
            end
        end
    end

    // registered pin copies of data-ready and the active edge
    always @(posedge I_CLK_SYS or posedge I_RST) begin
        if (I_RST) begin
            O_DATA_READY_N <= 1'b1;
            O_SCLK_ACTIVE <= 1'b0;
        end else begin
            O_DATA_READY_N <= data_ready_n_n_r;
            O_SCLK_ACTIVE <= sclk_act & ~rst_hold_r;
        end
    end

    // input pairing decode; unused codes select nothing
    always @* begin
        pos_nxt = `ASRPC_AIN_NONE;
        neg_nxt = `ASRPC_AIN_NONE;
        case (chan_r)
            `ASRPC_CHAN_D12: begin
                pos_nxt = `ASRPC_AIN_1;
                neg_nxt = `ASRPC_AIN_2;
            end
            `ASRPC_CHAN_D34: begin
                pos_nxt = `ASRPC_AIN_3;
                neg_nxt = `ASRPC_AIN_4;
            end
            `ASRPC_CHAN_P1: begin
                pos_nxt = `ASRPC_AIN_1;
                neg_nxt = `ASRPC_AIN_COMMON;
            end
            `ASRPC_CHAN_P2: begin
                pos_nxt = `ASRPC_AIN_2;
                neg_nxt = `ASRPC_AIN_COMMON;
            end
            `ASRPC_CHAN_P3: begin
                pos_nxt = `ASRPC_AIN_3;
                neg_nxt = `ASRPC_AIN_COMMON;
            end
            `ASRPC_CHAN_P4: begin
                pos_nxt = `ASRPC_AIN_4;
                neg_nxt = `ASRPC_AIN_COMMON;
            end
            default: begin
                pos_nxt = `ASRPC_AIN_NONE;
                neg_nxt = `ASRPC_AIN_NONE;
            end
        endcase
    end

    always @(posedge I_CLK_SYS or posedge I_RST) begin
        if (I_RST) begin
            O_MUX_POS <= `ASRPC_AIN_NONE;
            O_MUX_NEG <= `ASRPC_AIN_NONE;
        end else begin
            O_MUX_POS <= pos_nxt;
            O_MUX_NEG <= neg_nxt;
        end
    end

    // apb: answer prepared in setup, pready high in the first access cycle
    assign setup_ph = I_PSEL & ~I_PENABLE;
    assign access_wr = I_PSEL & I_PENABLE & O_PREADY & I_PWRITE;

    always @* begin
        rdata_nxt = 32'h0000_0000;
        rd_err_nxt = 1'b0;
        case (I_PADDR)
            `ASRPC_OFS_CHAN: rdata_nxt[`ASRPC_CHAN_W-1:0] = chan_r;
            `ASRPC_OFS_PERIOD: rdata_nxt[`ASRPC_PERIOD_W-1:0] = period_r;
            `ASRPC_OFS_STATUS: begin
                rdata_nxt[`ASRPC_ST_DATA_READY_N] = data_ready_n_n_r;
                rdata_nxt[`ASRPC_ST_SYNC] = sync_hold_r;
                rdata_nxt[`ASRPC_ST_RESET] = rst_hold_r;
                rdata_nxt[`ASRPC_ST_PARK] = sclk_parked;
                rdata_nxt[`ASRPC_ST_POL] = pol_s;
                rdata_nxt[`ASRPC_ST_BITS_HI:`ASRPC_ST_BITS_LO] = bit_cnt_r;
            end
            default: rd_err_nxt = 1'b1;
        endcase
    end

    always @(posedge I_CLK_SYS or posedge I_RST) begin
        if (I_RST) begin
            O_PREADY <= 1'b0;
            O_PRDATA <= 32'h0000_0000;
            O_PSLVERR <= 1'b0;
        end else begin
            O_PREADY <= setup_ph;
            if (setup_ph) begin
                O_PRDATA <= I_PWRITE ? 32'h0000_0000 : rdata_nxt;
                O_PSLVERR <= rd_err_nxt;
            end else if (!I_PSEL) begin
                O_PSLVERR <= 1'b0;
            end
        end
    end

    // writable control registers; pin reset returns them to power-on
    always @(posedge I_CLK_SYS or posedge I_RST) begin
        if (I_RST) begin
            chan_r <= `ASRPC_CHAN_RST;
            period_r <= `ASRPC_PERIOD_RST;
        end else if (rst_hold_r) begin
            chan_r <= `ASRPC_CHAN_RST;
            period_r <= `ASRPC_PERIOD_RST;
        end else if (access_wr) begin
            if (I_PADDR == `ASRPC_OFS_CHAN) begin
                chan_r <= I_PWDATA[`ASRPC_CHAN_W-1:0];
            end
            if (I_PADDR == `ASRPC_OFS_PERIOD) begin
                period_r <= I_PWDATA[`ASRPC_PERIOD_W-1:0];
            end
        end
    end
endmodule

//--- asrpc_properties.sv
`timescale 1ns/1ps
`include "asrpc_regs.vh"
module asrpc_checker (
    input wire I_CLK_SYS,
    input wire I_RST,
    input wire I_SCLK,
    input wire I_CLOCK_POLARITY_SELECT,
    input wire I_SYNC_N,
    input wire I_RESET_N,
    input wire I_MCLK_IN,
    input wire O_MCLK_OUT,
    input wire O_DATA_READY_N,
    input wire O_FILTER_RST,
    input wire O_MODULATOR_RST,
    input wire O_CAL_RST,
    input wire O_IF_RST,
    input wire O_SCLK_ACTIVE,
    input wire [2:0] O_MUX_POS,
    input wire [2:0] O_MUX_NEG
);
    default clocking @(posedge I_CLK_SYS); endclocking
    default disable iff (I_RST);
    // pin holds settle within the sync flops plus two registers
    AST_SYNC_HOLD: assert property (
        !I_SYNC_N [*5] |-> O_FILTER_RST && O_CAL_RST)
        else $error("sync low left filter or calibration running");
    AST_MOD_WITH_FILTER: assert property (
        O_MODULATOR_RST == O_FILTER_RST)
        else $error("modulator and filter holds differ");
    // window covers a short pin reset still inside the sync flops
    AST_IF_NOT_SYNC: assert property (
        I_RESET_N [*5] |-> !$rose(O_IF_RST))
        else $error("interface reset rose without pin reset");
    // quiet sclk while sync is low: data-ready must not rise
    AST_SYNC_KEEP_READY: assert property (
        (!I_SYNC_N && I_RESET_N) [*5] ##0
        (!O_DATA_READY_N && !O_SCLK_ACTIVE && !$past(O_SCLK_ACTIVE))
        |=> !O_DATA_READY_N)
        else $error("sync forced data-ready high");
    // data-ready needs one register more than the holds
    AST_RESET_HOLD: assert property (
        !I_RESET_N [*6] |-> O_IF_RST && O_MODULATOR_RST && O_DATA_READY_N)
        else $error("pin reset not held");
    AST_MCLK_INVERT: assert property (
        $rose(I_MCLK_IN) |-> ##[2:4] $fell(O_MCLK_OUT))
        else $error("master clock output not inverted");
    AST_ACTIVE_EDGE: assert property (
        O_SCLK_ACTIVE |-> I_SCLK != I_CLOCK_POLARITY_SELECT)
        else $error("serial edge of wrong direction counted");
    AST_PAIR_12: assert property (
        O_MUX_NEG == `ASRPC_AIN_2 |-> O_MUX_POS == `ASRPC_AIN_1)
        else $error("input two paired with wrong positive side");
    AST_PAIR_34: assert property (
        O_MUX_NEG == `ASRPC_AIN_4 |-> O_MUX_POS == `ASRPC_AIN_3)
        else $error("input four paired with wrong positive side");
    // release waits for the sync flops, never immediate
    AST_RELEASE_LAG: assert property (
        !I_RESET_N [*4] ##1 I_RESET_N |-> O_IF_RST [*2])
        else $error("pin reset released too early");
endmodule
bind asrpc_top asrpc_checker u_asrpc_checker (.I_CLK_SYS(I_CLK_SYS),
    .I_RST(I_RST), .I_SCLK(I_SCLK),
    .I_CLOCK_POLARITY_SELECT(I_CLOCK_POLARITY_SELECT), .I_SYNC_N(I_SYNC_N),
    .I_RESET_N(I_RESET_N), .I_MCLK_IN(I_MCLK_IN), .O_MCLK_OUT(O_MCLK_OUT),
    .O_DATA_READY_N(O_DATA_READY_N), .O_FILTER_RST(O_FILTER_RST),
    .O_MODULATOR_RST(O_MODULATOR_RST), .O_CAL_RST(O_CAL_RST),
    .O_IF_RST(O_IF_RST), .O_SCLK_ACTIVE(O_SCLK_ACTIVE),
    .O_MUX_POS(O_MUX_POS), .O_MUX_NEG(O_MUX_NEG));

//--- asrpc_host_model.sv
`timescale 1ns/1ps
module asrpc_host_model (
    input wire i_cps,
    input wire i_req,
    input wire [4:0] i_edges,
    input wire i_gap,
    output logic o_sclk,
    output logic o_done
);
    int k;
    // bursts of active edges at 125 ns; sclk rests between them
    initial begin
        o_done = 1'b0;
        forever begin
            o_sclk = i_cps; // park level follows polarity
            if (i_req && !o_done) begin
                for (k = 0; k < i_edges; k++) begin
                    if (i_gap && k == 12)
                        #500; // split word into two bursts
                    #62.5 o_sclk = !i_cps; // first edge leaves park
                    #62.5 o_sclk = i_cps;
                end
                o_done = 1'b1;
            end else if (!i_req)
                o_done = 1'b0;
            #1;
        end
    end
endmodule

//--- asrpc_bench.sv
`timescale 1ns/1ps
`include "asrpc_regs.vh"
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin err_count++; \
    $display("[FAIL] t=%0t got=%h exp=%h", $time, (a), (e)); end end
module asrpc_bench;
    logic clk, rst, psel, pen, pwr, cps, sync_n, reset_n, mclk, req, gap, e;
    logic [11:0] paddr;
    logic [31:0] pwdata, q;
    logic [4:0] edges;
    logic [2:0] mdiv;
    logic [2:0] mhist;
    wire [31:0] prdata;
    wire pready, pslverr, sclk, done, rdy_n, frst, mrst, crst, ifrst;
    wire mco, act;
    wire [2:0] mp, mn;
    int err_count, cmp_count, n, c, act_cnt, a0;

    asrpc_top u_asrpc_top (.I_CLK_SYS(clk), .I_RST(rst), .I_PSEL(psel),
        .I_PENABLE(pen), .I_PWRITE(pwr), .I_PADDR(paddr), .I_PWDATA(pwdata),
        .O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(pslverr),
        .I_SCLK(sclk), .I_CLOCK_POLARITY_SELECT(cps), .I_SYNC_N(sync_n),
        .I_RESET_N(reset_n), .I_MCLK_IN(mclk), .O_MCLK_OUT(mco),
        .O_DATA_READY_N(rdy_n), .O_FILTER_RST(frst), .O_MODULATOR_RST(mrst),
        .O_CAL_RST(crst), .O_IF_RST(ifrst), .O_SCLK_ACTIVE(act),
        .O_MUX_POS(mp), .O_MUX_NEG(mn));
    asrpc_host_model u_asrpc_host_model (.i_cps(cps), .i_req(req),
        .i_edges(edges), .i_gap(gap), .o_sclk(sclk), .o_done(done));

    // system clock, 4 ns
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    // master clock at an eighth of the system rate; mhist delays it
    // three cycles to line up with the output's sampling lag
    always @(posedge clk) begin
        if (rst)
            mdiv <= 3'h0;
        else
            mdiv <= mdiv + 3'h1;
        mclk <= mdiv[2];
        mhist <= {mhist[1:0], mclk};
        act_cnt <= act_cnt + (act === 1'b1);
    end

    task automatic report_and_stop();
        $display("compares=%0d mismatches=%0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic hang();
        err_count++;
        report_and_stop();
    endtask
    // one apb transfer; holds the request until pready is sampled
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        int k;
        psel <= 1'b1;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (pready !== 1'b1 && k < 16);
        if (pready !== 1'b1)
            hang();
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
        @(posedge clk);
    endtask
    // writes are dropped until the pin reset hold clears
    task automatic hold_clear();
        int k;
        k = 0;
        do begin
            apb(1'b0, `ASRPC_OFS_STATUS, 32'h0);
            k++;
        end while (q[`ASRPC_ST_RESET] !== 1'b0 && k < 64);
        if (k >= 64)
            hang();
    endtask
    task automatic wait_rdy(input logic lvl, input int lim);
        n = 0;
        while (rdy_n !== lvl) begin
            @(posedge clk);
            n++;
            if (n > lim)
                hang();
        end
    endtask
    // host clocks out k active edges, optionally in two bursts
    task automatic host(input logic [4:0] k, input logic g);
        edges <= k;
        gap <= g;
        req <= 1'b1;
        n = 0;
        while (done !== 1'b1) begin
            @(posedge clk);
            n++;
            if (n > 2000)
                hang();
        end
        req <= 1'b0;
        repeat (2) @(posedge clk);
    endtask
    function automatic logic [5:0] pair(input int ch);
        case (ch)
            0: pair = {`ASRPC_AIN_1, `ASRPC_AIN_2};
            1: pair = {`ASRPC_AIN_3, `ASRPC_AIN_4};
            2, 3, 4, 5: pair = {ch[2:0] - 3'h1, `ASRPC_AIN_COMMON};
            default: pair = {`ASRPC_AIN_NONE, `ASRPC_AIN_NONE};
        endcase
    endfunction

    initial begin
        {rst, sync_n, reset_n} = 3'h7;
        {psel, pen, pwr, cps, req, gap} = 6'h0;
        {paddr, pwdata, edges} = 49'h0;
        err_count = 0;
        cmp_count = 0;
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        hold_clear();
        // every channel pairing, then a refused write elsewhere
        for (c = 0; c < 8; c++) begin
            apb(1'b1, `ASRPC_OFS_CHAN, c);
            repeat (3) @(posedge clk);
            `CHK({mp, mn}, pair(c))
        end
        apb(1'b1, 12'h00c, 32'h1);
        `CHK(e, 1'b1)
        `CHK({mp, mn}, pair(7))
        // master clock out: pin inverted, three system cycles late
        repeat (16) begin
            @(posedge clk);
            `CHK(mco, ~mhist[2])
        end
        $display("end pairing");
        // full word read, rising edges, in two bursts
        apb(1'b1, `ASRPC_OFS_PERIOD, 32'h5dc);
        wait_rdy(1'b0, 14000);
        a0 = act_cnt;
        host(5'h18, 1'b1);
        `CHK(act_cnt - a0, 24)
        `CHK(rdy_n, 1'b1)
        apb(1'b0, `ASRPC_OFS_STATUS, 32'h0);
        `CHK(q[`ASRPC_ST_PARK], 1'b1)
        // falling edges; a partial word leaves data-ready low
        cps <= 1'b1;
        wait_rdy(1'b0, 14000);
        host(5'h0c, 1'b0);
        `CHK(rdy_n, 1'b0)
        host(5'h0c, 1'b1);
        `CHK(rdy_n, 1'b1)
        $display("end reads");
        // unread word: low 1000 then high 500 master periods
        wait_rdy(1'b0, 14000);
        wait_rdy(1'b1, 9000);
        `CHK(n > 7950 && n < 8050, 1'b1)
        wait_rdy(1'b0, 5000);
        `CHK(n > 3950 && n < 4050, 1'b1)
        $display("end window");
        // sync holds filter path only
        sync_n <= 1'b0;
        repeat (20) @(posedge clk);
        `CHK({frst,mrst,crst,ifrst,rdy_n}, 5'h1c)
        sync_n <= 1'b1;
        n = 0;
        while (frst !== 1'b0 && n < 64) begin
            @(posedge clk);
            n++;
        end
        `CHK(mrst, 1'b0)
        host(5'h18, 1'b0);
        `CHK(rdy_n, 1'b1)
        $display("end sync");
        // pin reset restores power-on state
        apb(1'b1, `ASRPC_OFS_CHAN, 32'h1);
        reset_n <= 1'b0;
        repeat (20) @(posedge clk);
        `CHK({ifrst, rdy_n, mrst}, 3'h7)
        reset_n <= 1'b1;
        hold_clear();
        apb(1'b0, `ASRPC_OFS_CHAN, 32'h0);
        `CHK(q, 32'h0)
        apb(1'b0, `ASRPC_OFS_PERIOD, 32'h0);
        `CHK(q, 32'h1000)
        `CHK(ifrst, 1'b0)
        $display("end reset");
        report_and_stop();
    end
endmodule
